// ### inc/nis_map.vh
/*
  register offsets, field positions, reset values and size limits of the
  network interface status block.
  assumes: included by bare name from the rtl files; no process lives here.
*/
`ifndef NIS_MAP_VH
`define NIS_MAP_VH

// ***************************************************************
// register map (byte addresses, one aligned word each)
// ***************************************************************
`define STAT_W0_OFF      8'h00
`define STAT_W1_OFF      8'h04
`define STAT_W2_OFF      8'h08
`define CTRL_OFF         8'h10
`define FAULT_STS_OFF    8'h14
`define FAULT_CLR_OFF    8'h18
`define FAULT_EN_OFF     8'h1c
`define FAULT_LAST_OFF   8'h20
`define LOG_COUNT_OFF    8'h24
`define LOG_DATA_OFF     8'h28
`define SCAN_CNT_OFF     8'h2c

// ***************************************************************
// status word fields (status bit n sits at word bit n-1)
// ***************************************************************
`define BIT_DUPLEX       2
`define BIT_LINK_GOOD    12
`define BIT_RESOURCE     13
`define BIT_INIT         15
`define STAT_WIDTH       80

// ***************************************************************
// control register fields
// ***************************************************************
`define CTRL_CONFIGURED  0
`define CTRL_ONLINE      1
`define CTRL_XCVR_CLR    2
`define CTRL_RESET       32'h0000_0000

// ***************************************************************
// fault codes, one sticky bit each
// ***************************************************************
`define FLT_STATE        0
`define FLT_BAD_CMD      1
`define FLT_WAIT_MODE    2
`define FLT_BAD_TASK     3
`define FLT_XCVR         4
`define FLT_NO_NODE      5
`define FLT_RESOURCE     6
`define FLT_NUM          7

// ***************************************************************
// command request fields and fault log size
// ***************************************************************
`define CMD_CODE_MAX     8'h0f
`define TASK_ID_MAX      4'h3
`define LOG_DEPTH        16
`define LOG_AW           4

`endif

// ### rtl/fault_log_mem.v
/*
  small fault log memory: one entry written per cycle, read data registered.
  assumes: single clock aclk; addresses in range.
*/
`timescale 1ns/1ps

module fault_log_mem (
  // clock
  input  wire        aclk,
  // write side
  input  wire        wr_en,
  input  wire [3:0]  wr_addr,
  input  wire [15:0] wr_data,
  // read side
  input  wire [3:0]  rd_addr,
  output reg  [15:0] rd_data
);

  reg [15:0] mem [0:15];

  // write port and registered read port
  always @(posedge aclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // fault_log_mem

// ### rtl/scan_tick.v
/*
  i/o scan divider: gives one-cycle enable pulse every PERIOD cycles.
  assumes: aclk at 20 MHz, synchronous active low reset.
*/
`timescale 1ns/1ps

module scan_tick #(
  parameter [15:0] PERIOD = 16'd20000
) (
  // clock and reset
  input  wire aclk,
  input  wire aresetn,
  // scan enable
  output reg  tick
);

  reg [15:0] count_reg;

  // free-running up counter
  always @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= 16'h0000;
      tick      <= 1'b0;
    end else if (count_reg == PERIOD - 16'd1) begin
      count_reg <= 16'h0000;
      tick      <= 1'b1;
    end else begin
      count_reg <= count_reg + 16'd1;
      tick      <= 1'b0;
    end
  end

endmodule // scan_tick

// ### rtl/network_interface_status_word.v
/*
  network interface status block: status region refreshed once per scan,
  fault reporting for command requests, transceiver failure and resource shortage, axi4-lite slave.
  assumes: one clock aclk at 20 MHz; link and request inputs synchronous
  to aclk; the switch side negotiates duplex and reports it on link inputs.
*/
// How it works
// - whole status region is captured afresh at each scan tick
// - status region starts at base offset, bit one at word zero bit zero
// - bit three shows full duplex, meaningful only while link good
// - duplex comes from autonegotiation input, never from a register
// - link good bit follows ability to communicate, returns automatically
// - resource bit set on shortage, cleared on a later scan by itself
// - initialized bit marks valid status; others invalid while zero
// - request while unconfigured or offline discarded and logged
// - request with invalid command code discarded and logged
// - request to unknown task identifier rejected and logged
// - transceiver failure logged, stays off network until cleared
// - request to unresolved remote node discarded and logged
`timescale 1ns/1ps
`include "nis_map.vh"

module network_interface_status_word #(
  parameter [15:0] SCAN_PERIOD = 16'd20000
) (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // network side status
  input  wire        phy_link_up,
  input  wire        phy_full_duplex,
  input  wire        xcvr_fail,
  input  wire        mem_shortage,
  input  wire        init_done,
  // command request port
  input  wire        command_request,
  input  wire [7:0]  cmd_code,
  input  wire [3:0]  cmd_task_id,
  input  wire        cmd_wait_mode,
  input  wire        cmd_node_unresolved,
  output reg         cmd_accept,
  output reg         cmd_discard,
  // network enable and interrupt
  output reg         net_enable,
  output wire        irq
);

  // ***************************************************************
  // state
  // ***************************************************************
  reg [79:0]         status_reg;
  reg [31:0]         ctrl_reg;
  reg [6:0]          fault_sts_reg;
  reg [6:0]          fault_en_reg;
  reg [6:0]          fault_last_reg;
  reg [15:0]         log_count_reg;
  reg [3:0]          log_wr_reg;
  reg [3:0]          log_rd_reg;
  reg [31:0]         scan_cnt_reg;
  reg                xcvr_fault_reg;
  reg                short_seen_reg;
  reg                ever_init_reg;
  wire               tick;
  wire [15:0]        log_rd_data;
  reg [6:0]          fault_evt;
  wire [6:0]         fault_clr;

  // ***************************************************************
  // scan divider and fault memory
  // ***************************************************************
  scan_tick #(
    .PERIOD (SCAN_PERIOD)
  ) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick)
  );

  fault_log_mem u_log (
    .aclk    (aclk),
    .wr_en   (|fault_evt),
    .wr_addr (log_wr_reg),
    .wr_data ({scan_cnt_reg[8:0], fault_evt}),
    .rd_addr (log_rd_reg),
    .rd_data (log_rd_data)
  );

  // lowest set fault bit as a one-hot mask; one entry per cycle, so simultaneous ones collapse
  function [6:0] first_one;
    input [6:0] v;
    begin
      first_one = v & (~v + 7'd1);
    end
  endfunction

  // ***************************************************************
  // command request checks, in priority order
  // ***************************************************************
  wire configured = ctrl_reg[`CTRL_CONFIGURED];
  wire online     = ctrl_reg[`CTRL_ONLINE] & ~xcvr_fault_reg;
  reg  [6:0] req_flt;

  always @* begin
    req_flt = 7'h00;
    if (command_request) begin
      if (!configured || !online || !ever_init_reg)
        req_flt[`FLT_STATE] = 1'b1;
      else if (cmd_wait_mode)
        req_flt[`FLT_WAIT_MODE] = 1'b1;
      else if (cmd_task_id > `TASK_ID_MAX)
        req_flt[`FLT_BAD_TASK] = 1'b1;
      else if (cmd_code > `CMD_CODE_MAX)
        req_flt[`FLT_BAD_CMD] = 1'b1;
      else if (cmd_node_unresolved)
        req_flt[`FLT_NO_NODE] = 1'b1;
    end
  end

  // all fault events of this cycle
  always @* begin
    fault_evt = req_flt;
    fault_evt[`FLT_XCVR]     = xcvr_fail & ~xcvr_fault_reg;
    fault_evt[`FLT_RESOURCE] = mem_shortage & ~short_seen_reg;
  end

  // accept and discard pulses, registered
  always @(posedge aclk) begin
    if (!aresetn) begin
      cmd_accept  <= 1'b0;
      cmd_discard <= 1'b0;
    end else begin
      cmd_accept  <= command_request & ~(|req_flt);
      cmd_discard <= |req_flt;
    end
  end

  // ***************************************************************
  // link fault latch and network enable
  // ***************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      xcvr_fault_reg <= 1'b0;
      net_enable     <= 1'b0;
      short_seen_reg <= 1'b0;
      ever_init_reg  <= 1'b0;
    end else begin
      // a still failing transceiver re-latches: set beats clear
      if (xcvr_fail)
        xcvr_fault_reg <= 1'b1;
      else if (fault_clr[`FLT_XCVR] || ctrl_reg[`CTRL_XCVR_CLR])
        xcvr_fault_reg <= 1'b0;
      net_enable     <= configured & ctrl_reg[`CTRL_ONLINE] & ~xcvr_fault_reg & ~xcvr_fail;
      short_seen_reg <= mem_shortage;
      if (init_done)
        ever_init_reg <= 1'b1;
    end
  end

  // ***************************************************************
  // status region refresh once per scan
  // ***************************************************************
  // shortage seen at any time between two scans shows for one scan
  reg short_pend_reg;
  always @(posedge aclk) begin
    if (!aresetn) begin
      status_reg     <= 80'h0;
      short_pend_reg <= 1'b0;
      scan_cnt_reg   <= 32'h0;
    end else begin
      if (tick) begin
        status_reg <= 80'h0;
        status_reg[`BIT_INIT] <= init_done;
        if (ever_init_reg) begin
          status_reg[`BIT_LINK_GOOD] <= phy_link_up & net_enable;
          status_reg[`BIT_DUPLEX]    <= phy_full_duplex & phy_link_up;
          status_reg[`BIT_RESOURCE]  <= short_pend_reg | mem_shortage;
        end
        scan_cnt_reg <= scan_cnt_reg + 32'd1;
      end
      short_pend_reg <= ~tick & (short_pend_reg | mem_shortage);
    end
  end

  // ***************************************************************
  // sticky fault status and log pointer
  // ***************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      fault_sts_reg  <= 7'h00;
      fault_last_reg <= 7'h00;
      log_count_reg  <= 16'h0000;
      log_wr_reg     <= 4'h0;
    end else begin
      // a new event wins over a clear in the same cycle
      fault_sts_reg <= (fault_sts_reg & ~fault_clr) | fault_evt;
      if (|fault_evt) begin
        fault_last_reg <= first_one(fault_evt);
        log_count_reg  <= log_count_reg + 16'd1;
        log_wr_reg     <= log_wr_reg + 4'd1;
      end
    end
  end

  assign irq = |(fault_sts_reg & fault_en_reg);

  // ***************************************************************
  // axi4-lite write channel
  // ***************************************************************
  reg        aw_held_reg;
  reg        w_held_reg;
  reg [7:0]  awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0]  wstrb_reg;
  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;
  wire       aw_now  = aw_held_reg | s_axi_awvalid;
  wire       w_now   = w_held_reg | s_axi_wvalid;
  wire       do_wr   = aw_now & w_now & ~s_axi_bvalid;
  wire [7:0] wa      = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  wire [31:0] wd     = w_held_reg ? wdata_reg : s_axi_wdata;
  wire [3:0]  ws     = w_held_reg ? wstrb_reg : s_axi_wstrb;

  // byte-lane merge used by the control and fault enable registers
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  be;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (be[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  // clear strobes and merged enable, decoded straight off the accepted write
  assign fault_clr = (do_wr && wa == `FAULT_CLR_OFF && ws[0]) ? wd[6:0] : 7'h00;
  wire [31:0] en_m = merge({25'h0, fault_en_reg}, wd, ws);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      awaddr_reg   <= 8'h00;
      wdata_reg    <= 32'h0;
      wstrb_reg    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
      ctrl_reg     <= `CTRL_RESET;
      fault_en_reg <= 7'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready && !do_wr) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready && !do_wr) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'b00;
        case (wa)
          `CTRL_OFF:      ctrl_reg     <= merge(ctrl_reg, wd, ws) & 32'h0000_0007;
          `FAULT_EN_OFF:  fault_en_reg <= en_m[6:0];
          `FAULT_CLR_OFF: s_axi_bresp  <= 2'b00;
          default:        s_axi_bresp  <= 2'b10;   // read-only or unmapped
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // axi4-lite read channel, two-stage so log memory data is ready
  // ***************************************************************
  localparam RD_IDLE = 3'b001;
  localparam RD_WAIT = 3'b010;
  localparam RD_DATA = 3'b100;
  reg [2:0] rd_state_reg;
  reg [7:0] araddr_reg;

  assign s_axi_arready = rd_state_reg[0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_reg <= RD_IDLE;
      araddr_reg   <= 8'h00;
      log_rd_reg   <= 4'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'b00;
    end else begin
      case (rd_state_reg)
        RD_IDLE: begin
          if (s_axi_arvalid) begin
            araddr_reg   <= s_axi_araddr;
            rd_state_reg <= RD_WAIT;
          end
        end
        RD_WAIT: begin
          s_axi_rvalid <= 1'b1;
          s_axi_rresp  <= 2'b00;
          rd_state_reg <= RD_DATA;
          case (araddr_reg)
            `STAT_W0_OFF:    s_axi_rdata <= status_reg[31:0];
            `STAT_W1_OFF:    s_axi_rdata <= status_reg[63:32];
            `STAT_W2_OFF:    s_axi_rdata <= {16'h0, status_reg[79:64]};
            `CTRL_OFF:       s_axi_rdata <= ctrl_reg;
            `FAULT_STS_OFF:  s_axi_rdata <= {25'h0, fault_sts_reg};
            `FAULT_CLR_OFF:  s_axi_rdata <= 32'h0;
            `FAULT_EN_OFF:   s_axi_rdata <= {25'h0, fault_en_reg};
            `FAULT_LAST_OFF: s_axi_rdata <= {25'h0, fault_last_reg};
            `LOG_COUNT_OFF:  s_axi_rdata <= {16'h0, log_count_reg};
            `LOG_DATA_OFF: begin
              // each read pops the next oldest slot
              s_axi_rdata <= {12'h0, log_rd_reg, log_rd_data};
              log_rd_reg  <= log_rd_reg + 4'd1;
            end
            `SCAN_CNT_OFF:   s_axi_rdata <= scan_cnt_reg;
            default: begin
              s_axi_rdata <= 32'h0;
              s_axi_rresp <= 2'b10;
            end
          endcase
        end
        RD_DATA: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rd_state_reg <= RD_IDLE;
          end
        end
        default: rd_state_reg <= RD_IDLE;
      endcase
    end
  end

endmodule // network_interface_status_word

// ### bench/nis_checker.sv
/* checker: command reply, discard and network enable properties.
   assumes: bound into the status block; single clock aclk. */
`timescale 1ns/1ps

module nis_checker #(
  parameter [15:0] SCAN_PERIOD = 16'd20000
) (
  // clock and reset
  input wire       aclk,
  input wire       aresetn,
  // network side
  input wire       xcvr_fail,
  input wire       init_done,
  input wire       net_enable,
  // command request port
  input wire       command_request,
  input wire [7:0] cmd_code,
  input wire [3:0] cmd_task_id,
  input wire       cmd_wait_mode,
  input wire       cmd_node_unresolved,
  input wire       cmd_accept,
  input wire       cmd_discard
);
  // **********
  // helpers
  // **********
  reg  seen_reg;
  wire good = (cmd_code <= 8'h0f) && (cmd_task_id <= 4'h3) && !cmd_wait_mode
              && !cmd_node_unresolved;

  // init seen at an earlier edge; same-edge init is left open
  always @(posedge aclk) begin
    if (!aresetn)
      seen_reg <= 1'h0;
    else if (init_done)
      seen_reg <= 1'h1;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // **********
  // properties
  // **********
  sequence drop_s;
    ##1 (cmd_discard && !cmd_accept);
  endsequence
  // net_enable one cycle on mirrors the control and fault state the request met
  sequence gate_off_s;
    command_request && !xcvr_fail ##1 !net_enable;
  endsequence
  sequence gate_on_s;
    command_request && seen_reg && good ##1 net_enable;
  endsequence

  state_drop_a: assert property (gate_off_s |-> cmd_discard && !cmd_accept)
    else $error("request while offline not discarded");
  uninit_drop_a: assert property (command_request && !seen_reg && !init_done |-> drop_s)
    else $error("request before init not discarded");
  good_take_a: assert property (gate_on_s |-> cmd_accept && !cmd_discard)
    else $error("valid request not accepted");
  code_drop_a: assert property (command_request && cmd_code > 8'h0f |-> drop_s)
    else $error("bad command code not discarded");
  wait_drop_a: assert property (command_request && cmd_wait_mode |-> drop_s)
    else $error("wait mode request not discarded");
  task_drop_a: assert property (command_request && cmd_task_id > 4'h3 |-> drop_s)
    else $error("unknown task id not rejected");
  node_drop_a: assert property (command_request && cmd_node_unresolved |-> drop_s)
    else $error("unresolved node request not discarded");
  xcvr_off_a: assert property ($rose(xcvr_fail) |-> ##[1:4] !net_enable)
    else $error("network left enabled after transceiver failure");
  xcvr_hold_a: assert property (xcvr_fail [*5] |-> !net_enable)
    else $error("network enabled while transceiver failed");
endmodule // nis_checker

bind network_interface_status_word nis_checker #(.SCAN_PERIOD(SCAN_PERIOD)) nis_checker_inst (
  .aclk(aclk), .aresetn(aresetn), .xcvr_fail(xcvr_fail), .init_done(init_done),
  .net_enable(net_enable), .command_request(command_request), .cmd_code(cmd_code),
  .cmd_task_id(cmd_task_id), .cmd_wait_mode(cmd_wait_mode),
  .cmd_node_unresolved(cmd_node_unresolved), .cmd_accept(cmd_accept),
  .cmd_discard(cmd_discard)
);

// ### bench/hub_model.sv
/* hub model: the switch port that faces the interface.
   assumes: tb sets plugged and the duplex the switch can offer. */
`timescale 1ns/1ps

module hub_model #(
  parameter [3:0] NEG_CYC = 4'h5
) (
  // clock
  input wire aclk,
  // test controls
  input wire plugged,
  input wire full_cap,
  // link status to the interface
  output reg phy_link_up,
  output reg phy_full_duplex
);
  reg [3:0] cnt_reg;

  initial begin
    cnt_reg = 4'h0;
    phy_link_up = 1'h0;
    phy_full_duplex = 1'h0;
  end

  // negotiation runs after plug-in; duplex wobbles while it is meaningless
  always @(posedge aclk) begin
    if (!plugged || cnt_reg != NEG_CYC) begin
      cnt_reg <= plugged ? cnt_reg + 4'h1 : 4'h0;
      phy_link_up <= 1'h0;
      phy_full_duplex <= ~phy_full_duplex;
    end else begin
      phy_link_up <= 1'h1;
      phy_full_duplex <= full_cap;
    end
  end
endmodule // hub_model

// ### bench/test_network_interface_status_word.sv
/* testbench: axi-lite register tests, status word, command faults.
   assumes: scan period shortened to 8 cycles; hub model on link pins. */
`timescale 1ns/1ps
`include "nis_map.vh"

module test_network_interface_status_word;
  localparam integer SP = 8;
  localparam [31:0] DPX = 32'h1 << `BIT_DUPLEX;
  localparam [31:0] LNK = 32'h1 << `BIT_LINK_GOOD;
  localparam [31:0] RES = 32'h1 << `BIT_RESOURCE;
  localparam [31:0] INI = 32'h1 << `BIT_INIT;

  reg         aclk = 1'h0, aresetn = 1'h0;
  reg  [7:0]  awaddr = 8'h0, araddr = 8'h0, cmd_code = 8'h0;
  reg  [31:0] wdata = 32'h0;
  reg         awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  reg         xcvr_fail = 1'h0, mem_shortage = 1'h0, init_done = 1'h0;
  reg         command_request = 1'h0, cmd_wait_mode = 1'h0, cmd_node_unresolved = 1'h0;
  reg  [3:0]  cmd_task_id = 4'h0;
  reg         plugged = 1'h1, full_cap = 1'h1;
  wire        awready, wready, bvalid, arready, rvalid, link_up, full_dpx;
  wire        cmd_accept, cmd_discard, net_enable, irq;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  integer     miscompares = 0, n_tests = 0, cyc = 0;

  always #25 aclk = ~aclk;

  network_interface_status_word #(.SCAN_PERIOD(16'd8)) network_interface_status_word_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .phy_link_up(link_up), .phy_full_duplex(full_dpx), .xcvr_fail(xcvr_fail),
    .mem_shortage(mem_shortage), .init_done(init_done),
    .command_request(command_request), .cmd_code(cmd_code), .cmd_task_id(cmd_task_id),
    .cmd_wait_mode(cmd_wait_mode), .cmd_node_unresolved(cmd_node_unresolved),
    .cmd_accept(cmd_accept), .cmd_discard(cmd_discard), .net_enable(net_enable), .irq(irq)
  );

  hub_model hub_model_inst (
    .aclk(aclk), .plugged(plugged), .full_cap(full_cap),
    .phy_link_up(link_up), .phy_full_duplex(full_dpx)
  );

  // **********
  // tasks
  // **********
  task stop_test;
    begin
      if (miscompares == 0 && n_tests > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  task ck(input [8*8:1] nm, input [31:0] e, input [31:0] g);
    begin
      n_tests = n_tests + 1;
      if (e !== g) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  // aw and w offered together, each dropped at its own handshake
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    begin
      @(posedge aclk);
      awaddr <= a; wdata <= d; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
      do begin
        @(posedge aclk);
        if (awready) awvalid <= 1'h0;
        if (wready) wvalid <= 1'h0;
      end while (!bvalid);
      bready <= 1'h0;
      ck("bresp", er, bresp);
    end
  endtask

  task rc(input [7:0] a, input [31:0] e, input [1:0] er);
    begin
      @(posedge aclk);
      araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
      do begin
        @(posedge aclk);
        if (arready) arvalid <= 1'h0;
      end while (!rvalid);
      rready <= 1'h0;
      ck("rresp", er, rresp);
      if (er == 2'h0) ck("rdata", e, rdata);
    end
  endtask

  // one-cycle request; reply is looked at in its single cycle
  task cmd(input [7:0] c, input [3:0] t, input w, input u, input acc);
    begin
      @(posedge aclk);
      command_request <= 1'h1; cmd_code <= c; cmd_task_id <= t;
      cmd_wait_mode <= w; cmd_node_unresolved <= u;
      @(posedge aclk);
      command_request <= 1'h0;
      #1;
      ck("accept", acc, cmd_accept);
      ck("discard", !acc, cmd_discard);
      @(posedge aclk);
    end
  endtask

  task scans(input integer n);
    repeat (n * SP) @(posedge aclk);
  endtask

  // hang guard, run needs well under this
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      stop_test;
    end
  end

  // **********
  // sequence
  // **********
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    rc(8'h00, 32'h0, 2'h0);
    rc(8'h0c, 32'h0, 2'h2);
    wr(8'h10, 32'h3, 2'h0);
    wr(8'h14, 32'h1, 2'h2);
    scans(2);
    rc(8'h00, 32'h0, 2'h0);
    cmd(8'h05, 4'h1, 1'h0, 1'h0, 1'h0);
    init_done <= 1'h1;
    scans(2);
    rc(8'h00, INI | LNK | DPX, 2'h0);
    rc(8'h04, 32'h0, 2'h0);
    rc(8'h08, 32'h0, 2'h0);
    full_cap <= 1'h0;
    scans(2);
    rc(8'h00, INI | LNK, 2'h0);
    plugged <= 1'h0;
    scans(2);
    rc(8'h00, INI, 2'h0);
    plugged <= 1'h1;
    scans(3);
    rc(8'h00, INI | LNK, 2'h0);
    cmd(8'h05, 4'h1, 1'h0, 1'h0, 1'h1);
    cmd(8'h0f, 4'h3, 1'h0, 1'h0, 1'h1);
    cmd(8'h10, 4'h0, 1'h0, 1'h0, 1'h0);
    cmd(8'h00, 4'h4, 1'h0, 1'h0, 1'h0);
    cmd(8'h00, 4'h0, 1'h1, 1'h0, 1'h0);
    cmd(8'h00, 4'h0, 1'h0, 1'h1, 1'h0);
    rc(8'h14, 32'h2f, 2'h0);
    wr(8'h18, 32'hff, 2'h0);
    rc(8'h14, 32'h0, 2'h0);
    wr(8'h10, 32'h1, 2'h0);
    cmd(8'h05, 4'h1, 1'h0, 1'h0, 1'h0);
    rc(8'h14, 32'h1, 2'h0);
    wr(8'h18, 32'hff, 2'h0);
    wr(8'h10, 32'h3, 2'h0);
    mem_shortage <= 1'h1;
    scans(2);
    rc(8'h00, INI | LNK | RES, 2'h0);
    ck("irq", 1'h0, irq);
    mem_shortage <= 1'h0;
    scans(2);
    rc(8'h00, INI | LNK, 2'h0);
    rc(8'h14, 32'h40, 2'h0);
    wr(8'h1c, 32'h40, 2'h0);
    ck("irq", 1'h1, irq);
    wr(8'h18, 32'h40, 2'h0);
    repeat (2) @(posedge aclk);
    ck("irq", 1'h0, irq);
    ck("netena", 1'h1, net_enable);
    xcvr_fail <= 1'h1;
    repeat (5) @(posedge aclk);
    ck("netena", 1'h0, net_enable);
    scans(2);
    rc(8'h00, INI, 2'h0);
    xcvr_fail <= 1'h0;
    repeat (5) @(posedge aclk);
    ck("netena", 1'h0, net_enable);
    wr(8'h18, 32'h10, 2'h0);
    repeat (3) @(posedge aclk);
    ck("netena", 1'h1, net_enable);
    rc(8'h20, 32'h10, 2'h0);
    rc(8'h24, 32'h8, 2'h0);
    stop_test;
  end
endmodule // test_network_interface_status_word
